// [inc/shcr_pkg.sv]
// Shared constants and types for the host control register bank
package shcr_pkg;

    // Register word offsets inside the 2 KB memory space
    localparam logic [10:0] OFF_UID_HI = 11'h024;
    localparam logic [10:0] OFF_UID_LO = 11'h028;
    localparam logic [10:0] OFF_ROM_BASE = 11'h034;
    localparam logic [10:0] OFF_PW_LO = 11'h038;
    localparam logic [10:0] OFF_PW_HI = 11'h03c;
    localparam logic [10:0] OFF_MAKER = 11'h040;
    localparam logic [10:0] OFF_HC_SET = 11'h050;
    localparam logic [10:0] OFF_HC_CLR = 11'h054;
    localparam logic [10:0] OFF_NID_BASE = 11'h064;
    localparam logic [10:0] OFF_NID_STAT = 11'h068;
    localparam logic [10:0] OFF_CH_HI_SET = 11'h070;
    localparam logic [10:0] OFF_CH_HI_CLR = 11'h074;
    localparam logic [10:0] OFF_CH_LO_SET = 11'h078;
    localparam logic [10:0] OFF_CH_LO_CLR = 11'h07c;
    localparam logic [10:0] OFF_EV_SET = 11'h080;
    localparam logic [10:0] OFF_EV_CLR = 11'h084;

    // Host control bit positions and implemented-bit masks
    localparam int HC_LINK_POWER = 19;
    localparam int HC_POSTED_WR = 18;
    localparam int HC_LINK_EN = 17;
    localparam int HC_SOFT_RST = 16;
    localparam logic [31:0] HC_MASK = 32'h000f0000;
    localparam logic [31:0] ROM_BASE_MASK = 32'hfffffc00;
    localparam logic [31:0] NID_BASE_MASK = 32'hfffff800;
    localparam logic [31:0] EV_MASK = 32'h07fb03ff;
    localparam logic [31:0] ZERO_WORD = 32'h00000000;

    // Event bit positions
    localparam int EV_PHY_REG_RX = 26;
    localparam int EV_CYC_LONG = 25;
    localparam int EV_UNRECOV = 24;
    localparam int EV_CYC_INCON = 23;
    localparam int EV_CYC_LOST = 22;
    localparam int EV_CYC_64S = 21;
    localparam int EV_CYC_SYNC = 20;
    localparam int EV_PHY_INT = 19;
    localparam int EV_BUS_RESET = 18 - 1;
    localparam int EV_NID_DONE = 16;
    localparam int EV_LOCK_ERR = 9;
    localparam int EV_PW_ERR = 8;

    // Config ROM window: 1 KB serviced, first five words are local
    localparam logic [11:0] ROM_WIN_BYTES = 12'h400;
    localparam logic [11:0] ROM_LOCAL_BYTES = 12'h014;

    // Timing: cycle too long is strictly more than 115 us, at most 120 us
    localparam int CLK_PERIOD_NS = 4;
    localparam int CYC_LONG_MIN_US = 115;
    localparam int CYC_LONG_MAX_US = 120;
    localparam int CYC_LONG_CYC = CYC_LONG_MIN_US * 1000 / CLK_PERIOD_NS + 1;
    localparam int CYC_LONG_MAX_CYC = CYC_LONG_MAX_US * 1000 / CLK_PERIOD_NS;
    localparam int SOFT_RST_CYC = 16;

    // Pulses from the link core that raise event bits directly
    typedef struct packed {
        logic phy_reg_rx;
        logic unrecov_err;
        logic cyc_lost;
        logic phy_int_req;
        logic bus_reset;
        logic lock_resp_err;
        logic [7:0] low_events;
    } shcr_hw_event_t;

    // Node announce receiver progress pulses
    typedef struct packed {
        logic start;
        logic word;
        logic done;
        logic error;
    } shcr_announce_t;

endpackage : shcr_pkg

// [core/shcr_regs.sv]
// Host control and status register bank of the serial bus link
`timescale 1ns/1ps
// What this block does
// - Unique ID cleared by hard reset, write-lockable
// - ROM space: only word reads below 1K
// - ROM base on 1K boundary, low bits zero
// - First five ROM words answered locally
// - Capture failed posted write offset, source ID
// - Set/clear addresses; read returns contents
// - Bit 19 gates PHY register traffic
// - Bit 18 selects pending ack or queue
// - Bit 17 enables packet traffic, reset clears
// - Bit 16 soft reset, self-clearing unless written while busy, reads busy
// - Announce buffer base bits 31-11, low zero
// - Announce error bit set and auto-cleared
// - Generation counts receptions, wraps after 255
// - Size counts words, bus reset clears
// - 64-bit channel mask with set/clear
// - Cycle too long after 115 us
// - Cycle inconsistent and cycle lost events
// - 64-second and cycle sync events
// - PHY data, PHY irq, bus reset, announce done
// - Unrecoverable, lock response, posted write errors
module shcr_regs #(
    parameter int CYC_LONG_LIMIT = shcr_pkg::CYC_LONG_CYC,
    parameter logic [31:0] MAKER_CODE = 32'h00c0ffee // Arbitrary value
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [10:0] req_addr,
    input wire logic [31:0] req_wdata,
    output logic rd_valid,
    output logic [31:0] rd_data,
    input wire logic id_write_lock_bit,
    input wire logic rom_req,
    input wire logic rom_word_read,
    input wire logic [11:0] rom_offset,
    output logic rom_done,
    output logic rom_type_error,
    output logic rom_local,
    output logic [31:0] rom_host_addr,
    input wire logic pw_err,
    input wire logic [47:0] pw_dest_offset,
    input wire logic [15:0] pw_source_id,
    input wire shcr_pkg::shcr_announce_t announce,
    input wire shcr_pkg::shcr_hw_event_t hw_event,
    input wire logic cs_tx_start,
    input wire logic sag_end,
    input wire logic cs_rx,
    input wire logic [12:0] cs_rx_count,
    input wire logic [12:0] local_cycle_count,
    input wire logic cycle_sec_bit7,
    output logic phy_reg_permit,
    output logic posted_wr_en,
    output logic link_en,
    output logic soft_reset_busy,
    output logic [63:0] rx_channel_mask,
    output logic [31:0] announce_base,
    output logic [31:0] event_flags
);

    logic [31:0] uid_hi_reg;
    logic [31:0] uid_lo_reg;
    logic [31:0] rom_base_reg;
    logic [31:0] pw_lo_reg;
    logic [31:0] pw_hi_reg;
    logic [31:0] hc_reg;
    logic [31:0] nid_base_reg;
    logic nid_err_reg;
    logic [7:0] nid_gen_reg;
    logic [10:0] nid_size_reg;
    logic [31:0] ch_hi_reg;
    logic [31:0] ch_lo_reg;
    logic [31:0] ev_reg;
    logic [31:0] ev_next;
    logic [31:0] hw_set;
    logic [4:0] srst_cnt_reg;
    logic [4:0] srst_age_reg;
    logic [15:0] long_cnt_reg;
    logic long_run_reg;
    logic sec7_reg;
    logic lsb_reg;
    logic wr;
    logic srst_start;
    logic long_hit;

    // Write strobe; all accesses are whole aligned words
    assign wr = req_valid && req_write;
    // soft reset starts on a set write while idle
    assign srst_start = wr && (req_addr == shcr_pkg::OFF_HC_SET)
        && req_wdata[shcr_pkg::HC_SOFT_RST] && (srst_cnt_reg == 5'h00);

    // unique ID, hard reset only, gated by the lock bit
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            uid_hi_reg <= shcr_pkg::ZERO_WORD;
            uid_lo_reg <= shcr_pkg::ZERO_WORD;
        end
        else if (clk_en && wr && !id_write_lock_bit)
        begin
            if (req_addr == shcr_pkg::OFF_UID_HI)
                uid_hi_reg <= req_wdata;
            if (req_addr == shcr_pkg::OFF_UID_LO)
                uid_lo_reg <= req_wdata;
        end
    end

    // ROM base keeps only 1K-aligned bits
    // announce base keeps only 2K-aligned bits
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rom_base_reg <= shcr_pkg::ZERO_WORD;
            nid_base_reg <= shcr_pkg::ZERO_WORD;
        end
        else if (clk_en)
        begin
            if (srst_start)
            begin
                rom_base_reg <= shcr_pkg::ZERO_WORD;
                nid_base_reg <= shcr_pkg::ZERO_WORD;
            end
            else if (wr && req_addr == shcr_pkg::OFF_ROM_BASE)
                rom_base_reg <= req_wdata & shcr_pkg::ROM_BASE_MASK;
            else if (wr && req_addr == shcr_pkg::OFF_NID_BASE)
                nid_base_reg <= req_wdata & shcr_pkg::NID_BASE_MASK;
        end
    end

    // failed write address captured on each posted write error
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pw_lo_reg <= shcr_pkg::ZERO_WORD;
            pw_hi_reg <= shcr_pkg::ZERO_WORD;
        end
        else if (clk_en && pw_err)
        begin
            pw_lo_reg <= pw_dest_offset[31:0];
            pw_hi_reg <= {pw_source_id, pw_dest_offset[47:32]};
        end
    end

    // link power cleared by both resets
    // link enable cleared by both resets
    // busy bit follows the soft reset counter
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            hc_reg <= shcr_pkg::ZERO_WORD;
        else if (clk_en)
        begin
            if (srst_start)
                hc_reg <= shcr_pkg::ZERO_WORD;
            else if (wr && req_addr == shcr_pkg::OFF_HC_SET)
                hc_reg <= hc_reg | (req_wdata & shcr_pkg::HC_MASK);
            else if (wr && req_addr == shcr_pkg::OFF_HC_CLR)
                hc_reg <= hc_reg & ~(req_wdata & shcr_pkg::HC_MASK);
        end
    end

    // Soft reset length; writes to bit 16 while busy do not restart it but stay set in hc_reg
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            srst_cnt_reg <= 5'h00;
        else if (clk_en)
        begin
            if (srst_start)
                srst_cnt_reg <= 5'(shcr_pkg::SOFT_RST_CYC);
            else if (srst_cnt_reg != 5'h00)
                srst_cnt_reg <= srst_cnt_reg - 5'h01;
        end
    end

    // Checker only: enabled cycles since soft reset began, stops at end
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            srst_age_reg <= 5'h00;
        else if (clk_en)
        begin
            if (srst_start)
                srst_age_reg <= 5'h01;
            else if (srst_age_reg != 5'h00
                && srst_age_reg < 5'(shcr_pkg::SOFT_RST_CYC + 1))
                srst_age_reg <= srst_age_reg + 5'h01;
        end
    end

    // channel mask set and clear words
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ch_hi_reg <= shcr_pkg::ZERO_WORD;
            ch_lo_reg <= shcr_pkg::ZERO_WORD;
        end
        else if (clk_en)
        begin
            if (srst_start)
            begin
                ch_hi_reg <= shcr_pkg::ZERO_WORD;
                ch_lo_reg <= shcr_pkg::ZERO_WORD;
            end
            else if (wr)
            begin
                if (req_addr == shcr_pkg::OFF_CH_HI_SET)
                    ch_hi_reg <= ch_hi_reg | req_wdata;
                if (req_addr == shcr_pkg::OFF_CH_HI_CLR)
                    ch_hi_reg <= ch_hi_reg & ~req_wdata;
                if (req_addr == shcr_pkg::OFF_CH_LO_SET)
                    ch_lo_reg <= ch_lo_reg | req_wdata;
                if (req_addr == shcr_pkg::OFF_CH_LO_CLR)
                    ch_lo_reg <= ch_lo_reg & ~req_wdata;
            end
        end
    end

    // error follows the outcome of the latest reception
    // generation bumps at each start and wraps naturally
    // size counts words, bus reset clears it
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            nid_err_reg <= 1'b0;
            nid_gen_reg <= 8'h00;
            nid_size_reg <= 11'h000;
        end
        else if (clk_en)
        begin
            if (announce.done)
                nid_err_reg <= announce.error;
            if (announce.start)
                nid_gen_reg <= nid_gen_reg + 8'h01;
            if (hw_event.bus_reset || srst_start)
                nid_size_reg <= 11'h000;
            else if (announce.word)
                nid_size_reg <= nid_size_reg + 11'h001;
        end
    end

    // time from cycle start send to subaction gap end
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            long_cnt_reg <= 16'h0000;
            long_run_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            if (cs_tx_start)
            begin
                long_cnt_reg <= 16'h0000;
                long_run_reg <= 1'b1;
            end
            else if (sag_end || long_hit)
                long_run_reg <= 1'b0;
            else if (long_run_reg)
                long_cnt_reg <= long_cnt_reg + 16'h0001;
        end
    end
    // Fires once, one cycle past the 115 us mark
    assign long_hit = long_run_reg && !sag_end
        && (long_cnt_reg == 16'(CYC_LONG_LIMIT - 1));

    // previous levels for change detection of the cycle timer
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sec7_reg <= 1'b0;
            lsb_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            sec7_reg <= cycle_sec_bit7;
            lsb_reg <= local_cycle_count[0];
        end
    end

    always_comb
    begin
        hw_set = shcr_pkg::ZERO_WORD;
        hw_set[shcr_pkg::EV_PHY_REG_RX] = hw_event.phy_reg_rx;
        hw_set[shcr_pkg::EV_CYC_LONG] = long_hit;
        hw_set[shcr_pkg::EV_UNRECOV] = hw_event.unrecov_err;
        hw_set[shcr_pkg::EV_CYC_INCON] = cs_rx
            && (cs_rx_count != local_cycle_count);
        hw_set[shcr_pkg::EV_CYC_LOST] = hw_event.cyc_lost;
        hw_set[shcr_pkg::EV_CYC_64S] = sec7_reg != cycle_sec_bit7;
        hw_set[shcr_pkg::EV_CYC_SYNC] = lsb_reg != local_cycle_count[0];
        hw_set[shcr_pkg::EV_PHY_INT] = hw_event.phy_int_req;
        hw_set[shcr_pkg::EV_BUS_RESET] = hw_event.bus_reset;
        hw_set[shcr_pkg::EV_NID_DONE] = announce.done;
        hw_set[shcr_pkg::EV_LOCK_ERR] = hw_event.lock_resp_err;
        hw_set[shcr_pkg::EV_PW_ERR] = pw_err;
        hw_set[7:0] = hw_event.low_events;
    end

    // Event flags: a hardware set in the clear cycle is kept
    always_comb
    begin
        ev_next = ev_reg;
        if (wr && req_addr == shcr_pkg::OFF_EV_SET)
            ev_next = ev_next | req_wdata;
        if (wr && req_addr == shcr_pkg::OFF_EV_CLR)
            ev_next = ev_next & ~req_wdata;
        ev_next = (ev_next | hw_set) & shcr_pkg::EV_MASK;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            ev_reg <= shcr_pkg::ZERO_WORD;
        else if (clk_en)
            // A hardware event in the soft reset cycle still sets its bit
            ev_reg <= srst_start ? (hw_set & shcr_pkg::EV_MASK) : ev_next;
    end

    // only word reads inside the first 1K are serviced
    // header and bus info words stay on chip
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rom_done <= 1'b0;
            rom_type_error <= 1'b0;
            rom_local <= 1'b0;
            rom_host_addr <= shcr_pkg::ZERO_WORD;
        end
        else if (clk_en)
        begin
            rom_done <= rom_req;
            rom_type_error <= rom_req && (!rom_word_read
                || rom_offset >= shcr_pkg::ROM_WIN_BYTES
                || rom_offset[1:0] != 2'b00);
            rom_local <= rom_req && rom_word_read
                && rom_offset < shcr_pkg::ROM_LOCAL_BYTES
                && rom_offset[1:0] == 2'b00;
            rom_host_addr <= rom_base_reg | {22'h000000, rom_offset[9:0]};
        end
    end

    // read mux; both addresses of a pair show the same word
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_valid <= 1'b0;
            rd_data <= shcr_pkg::ZERO_WORD;
        end
        else if (clk_en)
        begin
            rd_valid <= req_valid && !req_write;
            case (req_addr)
                shcr_pkg::OFF_UID_HI: rd_data <= uid_hi_reg;
                shcr_pkg::OFF_UID_LO: rd_data <= uid_lo_reg;
                shcr_pkg::OFF_ROM_BASE: rd_data <= rom_base_reg;
                shcr_pkg::OFF_PW_LO: rd_data <= pw_lo_reg;
                shcr_pkg::OFF_PW_HI: rd_data <= pw_hi_reg;
                shcr_pkg::OFF_MAKER: rd_data <= MAKER_CODE;
                shcr_pkg::OFF_HC_SET, shcr_pkg::OFF_HC_CLR:
                    rd_data <= hc_reg | {15'h0000, srst_cnt_reg != 5'h00,
                        16'h0000};
                shcr_pkg::OFF_NID_BASE: rd_data <= nid_base_reg;
                shcr_pkg::OFF_NID_STAT:
                    rd_data <= {nid_err_reg, 7'h00, nid_gen_reg, 3'h0,
                        nid_size_reg, 2'h0};
                shcr_pkg::OFF_CH_HI_SET, shcr_pkg::OFF_CH_HI_CLR:
                    rd_data <= ch_hi_reg;
                shcr_pkg::OFF_CH_LO_SET, shcr_pkg::OFF_CH_LO_CLR:
                    rd_data <= ch_lo_reg;
                shcr_pkg::OFF_EV_SET, shcr_pkg::OFF_EV_CLR:
                    rd_data <= ev_reg;
                default: rd_data <= shcr_pkg::ZERO_WORD;
            endcase
        end
    end

    // PHY register traffic only when link power is set
    // posted write queue enable; low means pending ack for all
    // the far side changes bit 18 only with link disabled
    assign phy_reg_permit = hc_reg[shcr_pkg::HC_LINK_POWER];
    assign posted_wr_en = hc_reg[shcr_pkg::HC_POSTED_WR];
    assign link_en = hc_reg[shcr_pkg::HC_LINK_EN];
    assign soft_reset_busy = srst_cnt_reg != 5'h00;
    assign rx_channel_mask = {ch_hi_reg, ch_lo_reg};
    assign announce_base = nid_base_reg;
    assign event_flags = ev_reg;

    // locked unique ID does not move on writes
    a_uid_lock_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && wr && id_write_lock_bit |=> $stable(uid_hi_reg)
        && $stable(uid_lo_reg))
        else $error("Unique ID changed while locked");

    // ROM base low bits always zero
    a_rom_base_align: assert property (@(posedge sys_clk) disable iff (!rst_n)
        rom_base_reg[9:0] == 10'h000)
        else $error("ROM base not 1K aligned");

    // non-word access earns a type error
    a_rom_reject: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && rom_req && !rom_word_read |=> rom_type_error && !rom_local)
        else $error("ROM non-read not rejected");

    // capture holds the upper offset bits and source
    a_pw_capture: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && pw_err |=> pw_hi_reg == {$past(pw_source_id),
        $past(pw_dest_offset[47:32])} && ev_reg[shcr_pkg::EV_PW_ERR])
        else $error("Posted write capture wrong");

    // busy holds for the whole soft reset then drops
    a_soft_rst_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
        srst_age_reg != 5'h00 |-> (soft_reset_busy
        == (srst_age_reg < 5'(shcr_pkg::SOFT_RST_CYC + 1)))
        && (srst_age_reg != 5'h01 || !link_en))
        else $error("Soft reset length wrong");

    // generation increments by one per start
    a_gen_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && announce.start |=> nid_gen_reg == $past(nid_gen_reg)
        + 8'h01)
        else $error("Generation did not step");

    a_size_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && hw_event.bus_reset |=> nid_size_reg == 11'h000
        && ev_reg[shcr_pkg::EV_BUS_RESET])
        else $error("Size not cleared by bus reset");

    // threshold sits below the 120 us end of the band
    a_cyc_long_band: assert property (@(posedge sys_clk) disable iff (!rst_n)
        long_hit |-> long_cnt_reg < 16'(shcr_pkg::CYC_LONG_MAX_CYC)
        ##1 ev_reg[shcr_pkg::EV_CYC_LONG] || !clk_en)
        else $error("Cycle too long out of band");

    // hardware set beats a simultaneous clear
    a_set_wins: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && announce.done |=> ev_reg[shcr_pkg::EV_NID_DONE])
        else $error("Announce done event lost");

    // set write enables the channel bits
    a_chan_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
        clk_en && wr && req_addr == shcr_pkg::OFF_CH_LO_SET && !srst_start
        |=> (ch_lo_reg & $past(req_wdata)) == $past(req_wdata))
        else $error("Channel set lost");

endmodule : shcr_regs

// [sim/shcr_host.sv]
// Host register master model: one word per request
`timescale 1ns/1ps
module shcr_host (
    input wire logic sys_clk,
    output logic req_valid = 1'b0,
    output logic req_write = 1'b0,
    output logic [10:0] req_addr = 11'h000,
    output logic [31:0] req_wdata = 32'h00000000,
    input wire logic rd_valid,
    input wire logic [31:0] rd_data
);
    // Held up to the taking edge; data inverted after so none is stale
    task automatic wr(input logic [10:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_write <= 1'b1;
        req_addr <= a;
        req_wdata <= v;
        @(posedge sys_clk);
        req_valid <= 1'b0;
        req_wdata <= ~v;
    endtask : wr
    // Answer looked for in a bounded window, ok low if none came
    task automatic rd(input logic [10:0] a, output logic [31:0] v,
        output logic ok);
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_write <= 1'b0;
        req_addr <= a;
        @(posedge sys_clk);
        req_valid <= 1'b0;
        ok = 1'b0;
        repeat (4)
            if (!ok)
            begin
                #1;
                ok = rd_valid === 1'b1;
                v = rd_data;
                if (!ok) @(posedge sys_clk);
            end
    endtask : rd
endmodule : shcr_host

// [sim/shcr_regs_tb_top.sv]
// Self-checking bench for the host control register bank
`timescale 1ns/1ps
module shcr_regs_tb_top;
    localparam int LIM = 20; // Short limit keeps the run brief
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic lock = 1'b0;
    logic rom_req = 1'b0;
    logic rom_wd = 1'b0;
    logic sec7 = 1'b0;
    logic [11:0] rom_off = 12'h000;
    logic [47:0] pw_off = 48'h000000000000;
    logic [15:0] pw_src = 16'h0000;
    logic [12:0] rx_cnt = 13'h0000;
    logic [12:0] loc_cnt = 13'h0000;
    logic [21:0] stim = 22'h000000;
    logic rv, rw, rd_valid, done, te, loc, busy, ok, w;
    logic [2:0] hc;
    logic [10:0] ad;
    logic [31:0] wd, rd_data, haddr, nbase, ev, d, a, b, c;
    logic [63:0] mask;
    logic [7:0] g;
    logic [11:0] o;
    logic [10:0] ra [7] = '{11'h024, 11'h028, 11'h050, 11'h070, 11'h078,
        11'h080, 11'h044};
    logic [11:0] ro [6] = '{12'h010, 12'h014, 12'h3fc, 12'h400, 12'h022,
        12'h004};
    logic [31:0] uid [2];
    int n_fail = 0;
    int comparisons = 0;
    int i, k;
    int m [6] = '{9, 17, 19, 22, 24, 26};
    initial forever #2 sys_clk = ~sys_clk;
    shcr_host HOST (.sys_clk(sys_clk), .req_valid(rv), .req_write(rw),
        .req_addr(ad), .req_wdata(wd), .rd_valid(rd_valid),
        .rd_data(rd_data));
    shcr_regs #(.CYC_LONG_LIMIT(LIM), .MAKER_CODE(32'h1234abcd)) DUT (
        .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1), .req_valid(rv),
        .req_write(rw), .req_addr(ad), .req_wdata(wd),
        .rd_valid(rd_valid), .rd_data(rd_data), .id_write_lock_bit(lock),
        .rom_req(rom_req), .rom_word_read(rom_wd), .rom_offset(rom_off),
        .rom_done(done), .rom_type_error(te), .rom_local(loc),
        .rom_host_addr(haddr), .pw_err(stim[21]), .pw_dest_offset(pw_off),
        .pw_source_id(pw_src),
        .announce(shcr_pkg::shcr_announce_t'(stim[20:17])),
        .hw_event(shcr_pkg::shcr_hw_event_t'(stim[16:3])),
        .cs_tx_start(stim[2]), .sag_end(stim[1]), .cs_rx(stim[0]),
        .cs_rx_count(rx_cnt), .local_cycle_count(loc_cnt),
        .cycle_sec_bit7(sec7), .phy_reg_permit(hc[2]),
        .posted_wr_en(hc[1]), .link_en(hc[0]), .soft_reset_busy(busy),
        .rx_channel_mask(mask), .announce_base(nbase), .event_flags(ev));
    // Word compare; every result is widened to one word
    task automatic chk(input logic [31:0] gv, input logic [31:0] xv);
        comparisons++;
        if (gv !== xv)
        begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, gv, xv);
        end
    endtask : chk
    task automatic close_out();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    // A lost answer counts once and ends the run
    task automatic rdc(input logic [10:0] ra_a, input logic [31:0] xv);
        HOST.rd(ra_a, d, ok);
        if (ok)
            chk(d, xv);
        else
        begin
            n_fail++;
            close_out();
        end
    endtask : rdc
    // One-cycle strobe on the event and announce inputs
    task automatic pulse(input logic [21:0] v);
        @(posedge sys_clk);
        stim <= v;
        @(posedge sys_clk);
        stim <= 22'h000000;
        #1;
    endtask : pulse
    initial
    begin
        void'($urandom(17));
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        foreach (ra[j]) rdc(ra[j], 32'h00000000);
        rdc(11'h040, 32'h1234abcd);
        for (i = 0; i < 2; i++)
        begin
            uid[i] = $urandom;
            HOST.wr(ra[i], uid[i]);
            @(posedge sys_clk) lock <= 1'b1;
            HOST.wr(ra[i], ~uid[i]);
            rdc(ra[i], uid[i]);
            @(posedge sys_clk) lock <= 1'b0;
        end
        // Posted write first, link later, reserved bits read zero
        HOST.wr(11'h050, 32'hfff4ffff);
        rdc(11'h054, 32'h00040000);
        HOST.wr(11'h050, 32'h000a0000);
        rdc(11'h050, 32'h000e0000);
        chk({29'h0, hc}, 32'h7);
        HOST.wr(11'h054, 32'hfffaffff);
        rdc(11'h050, 32'h00040000);
        chk({29'h0, hc}, 32'h2);
        $display("test host_control done");
        a = $urandom;
        HOST.wr(11'h034, a);
        rdc(11'h034, a & 32'hfffffc00);
        for (i = 0; i < 14; i++)
        begin
            o = i < 6 ? ro[i] : 12'($urandom_range(1279));
            w = i != 5 && (i < 6 || $urandom_range(3) != 0);
            @(posedge sys_clk);
            rom_req <= 1'b1;
            rom_wd <= w;
            rom_off <= o;
            @(posedge sys_clk);
            rom_req <= 1'b0;
            #1;
            k = int'(!w || o >= 12'h400 || o[1:0] != 2'b00);
            chk({done, te, loc}, {1'b1, k == 1, k == 0 && o < 12'h014});
            chk(haddr, (a & 32'hfffffc00) | {22'h0, o[9:0]});
        end
        @(posedge sys_clk);
        pw_off <= {$urandom, 16'($urandom)};
        pw_src <= 16'($urandom);
        pulse(22'h200000);
        rdc(11'h038, pw_off[31:0]);
        rdc(11'h03c, {pw_src, pw_off[47:32]});
        chk(ev, 32'h00000100);
        b = $urandom;
        c = $urandom;
        HOST.wr(11'h070, a);
        HOST.wr(11'h078, b);
        HOST.wr(11'h074, c);
        HOST.wr(11'h07c, ~c);
        rdc(11'h070, a & ~c);
        rdc(11'h07c, b & c);
        chk(mask[31:0], b & c);
        chk(mask[63:32], a & ~c);
        HOST.wr(11'h064, b);
        rdc(11'h064, b & 32'hfffff800);
        chk(nbase, b & 32'hfffff800);
        HOST.rd(11'h068, d, ok);
        g = d[23:16];
        // Generation walks all the way round and three more
        repeat (259) pulse(22'h100000);
        k = $urandom_range(7, 1);
        repeat (k) pulse(22'h080000);
        pulse(22'h060000);
        rdc(11'h068, {8'h80, g + 8'h03, 3'h0, 11'(k), 2'h0});
        pulse(22'h040000);
        pulse(22'h001000);
        rdc(11'h068, {8'h00, g + 8'h03, 16'h0000});
        $display("test announce done");
        for (i = 0; i < 14; i++)
        begin
            HOST.wr(11'h084, 32'hffffffff);
            pulse(22'h000008 << i);
            chk(ev, 32'h1 << (i < 8 ? i : m[i - 8]));
        end
        rdc(11'h080, 32'h04000000);
        HOST.wr(11'h084, 32'hffffffff);
        @(posedge sys_clk) rx_cnt <= 13'h0005;
        pulse(22'h000001);
        chk(ev, 32'h00800000);
        @(posedge sys_clk) loc_cnt <= 13'h0005;
        repeat (2) @(posedge sys_clk) sec7 <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        chk(ev, 32'h00b00000);
        HOST.wr(11'h084, 32'hffffffff);
        pulse(22'h000001);
        pulse(22'h000004);
        repeat (5) @(posedge sys_clk);
        pulse(22'h000002);
        repeat (LIM + 10) @(posedge sys_clk);
        #1;
        chk(ev, 32'h00000000);
        pulse(22'h000004);
        repeat (LIM + 10) @(posedge sys_clk);
        #1;
        chk(ev, 32'h02000000);
        $display("test events done");
        HOST.wr(11'h050, 32'h000a0000);
        HOST.wr(11'h050, 32'h00010000);
        HOST.rd(11'h050, d, ok);
        chk({30'h0, ok, d[16]}, 32'h3);
        for (i = 0; i < 40 && busy !== 1'b0; i++) @(posedge sys_clk);
        #1;
        if (busy !== 1'b0)
        begin
            n_fail++;
            close_out();
        end
        foreach (ra[j]) rdc(ra[j], j < 2 ? uid[j] : 32'h0);
        rdc(11'h034, 32'h00000000);
        rdc(11'h068, {8'h00, g + 8'h03, 16'h0000});
        chk({29'h0, hc}, 32'h0);
        $display("test soft_reset done");
        close_out();
    end
endmodule : shcr_regs_tb_top
